// ==== src/ssrcb_pkg.sv ====
// constants and types shared by the spi status read/clear bank
package ssrcb_pkg;

  // ==========================================================================
  // frame layout
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned ADDR_BITS = 7;
  localparam int unsigned MODE_BIT_POS = 7;
  localparam int unsigned DATA_LSB_POS = 8;
  localparam logic [4:0] FRAME_BITS_CNT = 5'h10;
  localparam logic [4:0] ADDR_DONE_CNT = 5'h07;
  localparam logic [4:0] DATA_FIRST_CNT = 5'h08;

  // ==========================================================================
  // status address map
  localparam logic [6:0] ADDR_GENERAL_BASE = 7'h40;
  localparam logic [6:0] ADDR_SWK_BASE = 7'h70;
  localparam logic [6:0] ADDR_SUPPLY_FAIL_1 = 7'h40;
  localparam logic [6:0] ADDR_WAKE_LEVEL = 7'h48;
  localparam logic [6:0] ADDR_CDR_STATUS_1 = 7'h72;
  localparam logic [6:0] ADDR_CDR_STATUS_2 = 7'h73;
  localparam logic [6:0] ADDR_FAMILY_ID = 7'h7E;

  // read/clear bytes whose fields are held generically
  localparam int unsigned NUM_RC = 10;
  localparam logic [6:0] RC_ADDR [NUM_RC] = '{7'h41, 7'h42, 7'h43, 7'h44, 7'h46,
                                               7'h47, 7'h54, 7'h55, 7'h70, 7'h71};
  // bits latched by the bank; device status bits 3:2 are the live watchdog counter
  localparam logic [7:0] RC_LATCH_MASK [NUM_RC] = '{8'hFF, 8'hFF, 8'hF3, 8'hFF, 8'hFF,
                                                     8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam int unsigned RC_DEV_IDX = 2;
  localparam int unsigned WATCHDOG_FAILURE_COUNTER_LSB = 2;
  localparam int unsigned NUM_LEVEL = 3;

  // ==========================================================================
  // supply-fail status byte
  localparam int unsigned SFS_UV_BIT = 6;
  localparam int unsigned SFS_OV_BIT = 5;
  localparam int unsigned SFS_MOV_BIT = 1;
  localparam int unsigned SFS_WARN_BIT = 0;
  localparam logic [7:0] SFS_RESET = 8'h00;
  localparam logic [7:0] SFS_RESERVED_MASK = 8'h9C;
  localparam logic [7:0] SFS_CLEAR_MASK = 8'h63;
  localparam logic [7:0] SFS_RESTART_KEEP = 8'h63;
  localparam logic [7:0] RC_RESET = 8'h00;

  localparam int unsigned SYNC_STAGES = 2;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic supply_undervoltage;
    logic supply_overvoltage;
    logic main_regulator_overvoltage;
    logic main_regulator_prewarning;
  } ssrcb_cmp_type;

  typedef struct packed {
    logic [4:0] bit_cnt;
    logic [FRAME_BITS-1:0] rx;
    logic [7:0] tx;
    logic miso;
    logic cs_q;
    logic sclk_q;
    logic frame_done;
    logic uv_mon;
    logic ov_mon;
    logic [7:0] sup1;
    logic [NUM_RC-1:0][7:0] rc;
  } ssrcb_state_type;

endpackage

// ==== src/ssrcb_sync.sv ====
// two-flop synchroniser for pins and analog comparator levels
`timescale 1ns/1ps
module ssrcb_sync
  import ssrcb_pkg::*;
#(
  parameter int unsigned WIDTH = 8
)
(
  input wire logic clk_i,              // bank clock
  input wire logic arst_n_i,           // async reset, active low
  input wire logic ce_i,               // clock enable
  input wire logic [WIDTH-1:0] d_i,    // asynchronous levels
  output logic [WIDTH-1:0] q_o         // synchronised levels
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ssrcb_sync_state_type;

  ssrcb_sync_state_type sync_r;
  ssrcb_sync_state_type sync_nxt;

  // ==========================================================================
  // stage one feeds stage two only
  always_comb
  begin
    sync_nxt = sync_r;
    if (ce_i)
    begin
      sync_nxt.s1 = d_i;
      sync_nxt.s2 = sync_r.s1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sync_r <= '0;
    else
      sync_r <= sync_nxt;
  end

  assign q_o = sync_r.s2;

endmodule

// ==== src/ssrcb_bank.sv ====
// spi status read/clear register bank with supply-fail status byte
`timescale 1ns/1ps

// Notes on behaviour
// - a status access is one 16-bit frame: 7-bit address plus mode bit, then a data byte.
// - register bits 0..7 travel in frame bits 8..15.
// - frame bit 7 low reads the addressed byte and leaves its flags alone.
// - frame bit 7 high clears the clearable bits of the addressed byte as a whole.
// - read-only and reserved bits ignore clears; read/clear bits can be read and cleared.
// - flags stay latched until the host clears them, except the watchdog failure counter.
// - general status decodes from 0x40, selective wake from 0x70, family id at 0x7E.
// - supply-fail byte resets to zero on power-on or soft reset; restart clears bits 7,4,3,2 only.
// - bit 7 and bits 4:2 of the supply-fail byte always read zero.
// - bit 6 latches supply undervoltage, detected only while the main regulator output is on.
// - bit 5 latches supply overvoltage, detected only while the main regulator output is on.
// - bit 1 latches main regulator overvoltage until the host clears it.
// - bit 0 latches the main regulator prewarning from a fixed threshold comparator.
// - in stop mode undervoltage monitoring is off unless load current is high or prewarning set.
// - overvoltage monitoring runs when the charge pump is enabled, else in stop mode only on high load or prewarning.
module ssrcb_bank
  import ssrcb_pkg::*;
#(
  parameter logic [7:0] FAMILY_ID = 8'hA5    // arbitrary identification value
)
(
  input wire logic clk_i,                                   // 20 MHz bank clock
  input wire logic arst_n_i,                                // power-on reset, active low
  input wire logic ce_i,                                    // clock enable, freezes all state
  input wire logic soft_reset_i,                            // soft reset pulse
  input wire logic restart_i,                               // restart pulse
  input wire logic spi_clk_i,                               // spi clock pin
  input wire logic spi_cs_n_i,                              // spi chip select pin, active low
  input wire logic spi_mosi_i,                              // spi data in pin
  output logic spi_miso_o,                                  // spi data out
  output logic spi_miso_oe_n_o,                             // miso drive enable, active low
  input wire ssrcb_cmp_type supply_cmp_i,                   // analog comparator levels
  input wire logic load_current_peak_i,                     // regulator load above peak threshold
  input wire logic main_regulator_output_i,                 // main regulator output enabled
  input wire logic stop_mode_i,                             // device in stop mode
  input wire logic charge_pump_enable_i,                    // charge pump enable bit
  input wire logic [1:0] watchdog_failure_counter_i,        // live watchdog failure count
  input wire logic [NUM_RC-1:0][7:0] status_event_i,        // set pulses of generic status bytes
  input wire logic [NUM_LEVEL-1:0][7:0] level_status_i,     // live read-only bytes
  output logic uv_monitor_on_o,                             // undervoltage monitor active
  output logic ov_monitor_on_o,                             // overvoltage monitor active
  output logic frame_done_o                                 // pulse after each full frame
);

  // ==========================================================================
  // pin synchronisation
  localparam int unsigned SYNC_W = 8;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic sclk_s;
  logic cs_act_s;
  logic mosi_s;
  logic peak_s;
  ssrcb_cmp_type cmp_s;

  // chip select inverted first so a reset synchroniser reads as idle
  assign sync_in = {supply_cmp_i, load_current_peak_i, spi_mosi_i, ~spi_cs_n_i, spi_clk_i};

  ssrcb_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .d_i(sync_in),
    .q_o(sync_out)
  );

  assign sclk_s = sync_out[0];
  assign cs_act_s = sync_out[1];
  assign mosi_s = sync_out[2];
  assign peak_s = sync_out[3];
  assign cmp_s = sync_out[7:4];

  // ==========================================================================
  // state and frame events
  ssrcb_state_type st_r;
  ssrcb_state_type st_nxt;

  logic sclk_rise;
  logic sclk_fall;
  logic cs_start;
  logic cs_end;
  logic frame_ok;
  logic clear_req;
  logic [6:0] frame_addr;
  logic [7:0] sup1_set;
  logic [7:0] sup1_clr;
  logic [NUM_RC-1:0][7:0] rc_upd;

  assign sclk_rise = sclk_s & ~st_r.sclk_q;
  assign sclk_fall = ~sclk_s & st_r.sclk_q;
  assign cs_start = cs_act_s & ~st_r.cs_q;
  assign cs_end = ~cs_act_s & st_r.cs_q;
  // short frames are dropped, never half applied; longer frames act on their first 16 bits
  assign frame_ok = cs_end && (st_r.bit_cnt == FRAME_BITS_CNT);
  assign frame_addr = st_r.rx[ADDR_BITS-1:0];
  assign clear_req = frame_ok && st_r.rx[MODE_BIT_POS];

  // ==========================================================================
  // supply-fail set events, undervoltage and overvoltage gated by the registered monitor enables
  always_comb
  begin
    sup1_set = 8'h00;
    sup1_set[SFS_UV_BIT] = cmp_s.supply_undervoltage & st_r.uv_mon;
    sup1_set[SFS_OV_BIT] = cmp_s.supply_overvoltage & st_r.ov_mon;
    sup1_set[SFS_MOV_BIT] = cmp_s.main_regulator_overvoltage;
    // fixed threshold comparator, no link to the reset threshold select
    sup1_set[SFS_WARN_BIT] = cmp_s.main_regulator_prewarning;
    sup1_clr = (clear_req && frame_addr == ADDR_SUPPLY_FAIL_1) ? SFS_CLEAR_MASK : 8'h00;
  end

  // ==========================================================================
  // generic read/clear bytes, one entry per status address
  genvar g;
  generate
    for (g = 0; g < NUM_RC; g++)
    begin : g_rc
      logic [7:0] clr;
      assign clr = (clear_req && frame_addr == RC_ADDR[g]) ? 8'hFF : 8'h00;
      // set after clear so a coinciding event survives
      assign rc_upd[g] = ((st_r.rc[g] & ~clr) | status_event_i[g]) & RC_LATCH_MASK[g];
    end
  endgenerate

  // ==========================================================================
  // read multiplexer, unmapped addresses read as zero
  function automatic logic [7:0] read_byte(input logic [6:0] addr, input ssrcb_state_type s,
                                           input logic [NUM_LEVEL-1:0][7:0] lvl,
                                           input logic [1:0] wd);
    logic [7:0] v;
    v = 8'h00;
    // only the general and selective wake windows decode
    if (addr >= ADDR_GENERAL_BASE)
    begin
      if (addr == ADDR_SUPPLY_FAIL_1)
        v = s.sup1 & ~SFS_RESERVED_MASK;
      else if (addr == ADDR_WAKE_LEVEL)
        v = lvl[0];
      else if (addr == ADDR_CDR_STATUS_1 && addr >= ADDR_SWK_BASE)
        v = lvl[1];
      else if (addr == ADDR_CDR_STATUS_2)
        v = lvl[2];
      else if (addr == ADDR_FAMILY_ID)
        v = FAMILY_ID;
      for (int i = 0; i < NUM_RC; i++)
      begin
        if (addr == RC_ADDR[i])
          v = s.rc[i];
      end
      // watchdog counter is shown live and never latched
      if (addr == RC_ADDR[RC_DEV_IDX])
        v[WATCHDOG_FAILURE_COUNTER_LSB +: 2] = wd;
    end
    return v;
  endfunction

  // ==========================================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    if (ce_i)
    begin
      st_nxt.sclk_q = sclk_s;
      st_nxt.cs_q = cs_act_s;
      st_nxt.frame_done = frame_ok;
      // monitors use last cycle's prewarning flag to stay glitch free
      st_nxt.uv_mon = main_regulator_output_i
                      & (~stop_mode_i | peak_s | st_r.sup1[SFS_WARN_BIT]);
      st_nxt.ov_mon = main_regulator_output_i
                      & (charge_pump_enable_i | ~stop_mode_i | peak_s | st_r.sup1[SFS_WARN_BIT]);

      // shift engine: sample on rising, drive on falling, lsb first
      if (cs_start)
      begin
        st_nxt.bit_cnt = 5'h00;
        st_nxt.miso = 1'b0;
      end
      else if (cs_act_s && sclk_rise && st_r.bit_cnt < FRAME_BITS_CNT)
      begin
        st_nxt.rx[st_r.bit_cnt[3:0]] = mosi_s;
        st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
        // address complete as the mode bit arrives: fetch the byte before the data phase
        if (st_r.bit_cnt == ADDR_DONE_CNT)
          st_nxt.tx = read_byte(frame_addr, st_r, level_status_i, watchdog_failure_counter_i);
      end
      else if (cs_act_s && sclk_fall && st_r.bit_cnt >= DATA_FIRST_CNT
               && st_r.bit_cnt < FRAME_BITS_CNT)
      begin
        st_nxt.miso = st_r.tx[st_r.bit_cnt[2:0]];
      end
      else if (!cs_act_s)
      begin
        st_nxt.miso = 1'b0;
      end

      // flags: set wins over clear, resets win over both
      st_nxt.sup1 = ((st_r.sup1 & ~sup1_clr) | sup1_set) & ~SFS_RESERVED_MASK;
      st_nxt.rc = rc_upd;
      if (soft_reset_i)
      begin
        st_nxt.sup1 = SFS_RESET;
        st_nxt.rc = '0;
      end
      else if (restart_i)
      begin
        // masks the normal update so an event in the restart cycle is not lost
        st_nxt.sup1 = st_nxt.sup1 & SFS_RESTART_KEEP;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ==========================================================================
  // outputs, all from flops
  assign spi_miso_o = st_r.miso;
  assign spi_miso_oe_n_o = ~st_r.cs_q;
  assign uv_monitor_on_o = st_r.uv_mon;
  assign ov_monitor_on_o = st_r.ov_mon;
  assign frame_done_o = st_r.frame_done;

  // ==========================================================================
  // checks
  logic quiet_sup;
  assign quiet_sup = ce_i && !soft_reset_i && !restart_i && (sup1_set == 8'h00);

  chk_frame_len: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    st_r.bit_cnt <= FRAME_BITS_CNT)
    else $error("bit counter ran past sixteen");

  chk_data_lane: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && cs_act_s && sclk_fall && !cs_start && st_r.bit_cnt >= DATA_FIRST_CNT
     && st_r.bit_cnt < FRAME_BITS_CNT) |=> (spi_miso_o == $past(st_r.tx[st_r.bit_cnt[2:0]])))
    else $error("data byte bit not driven on its frame slot");

  chk_read_keeps: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (frame_ok && !st_r.rx[MODE_BIT_POS] && quiet_sup) |=> (st_r.sup1 == $past(st_r.sup1)))
    else $error("read frame changed supply flags");

  chk_clear_sup: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (clear_req && frame_addr == ADDR_SUPPLY_FAIL_1 && quiet_sup) |=> (st_r.sup1 == 8'h00))
    else $error("clear frame did not wipe supply flags");

  chk_unmapped_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && cs_act_s && sclk_rise && !cs_start && st_r.bit_cnt == ADDR_DONE_CNT
     && frame_addr < ADDR_GENERAL_BASE) |=> (st_r.tx == 8'h00))
    else $error("address below status window returned data");

  chk_soft_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && soft_reset_i) |=> (st_r.sup1 == SFS_RESET))
    else $error("soft reset left supply flags set");

  chk_restart_keep: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && restart_i && !soft_reset_i)
    |=> (st_r.sup1 == ((($past(st_r.sup1) & ~$past(sup1_clr)) | $past(sup1_set)) & SFS_RESTART_KEEP)))
    else $error("restart changed kept supply bits");

  chk_reserved_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st_r.sup1 & SFS_RESERVED_MASK) == 8'h00)
    else $error("reserved supply bit set");

  chk_uv_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && !st_r.uv_mon && !st_r.sup1[SFS_UV_BIT]) |=> !st_r.sup1[SFS_UV_BIT])
    else $error("undervoltage latched while monitor off");

  chk_ov_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && !st_r.ov_mon && !st_r.sup1[SFS_OV_BIT]) |=> !st_r.sup1[SFS_OV_BIT])
    else $error("overvoltage latched while monitor off");

  chk_mov_sticky: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st_r.sup1[SFS_MOV_BIT] && !soft_reset_i && !(clear_req && frame_addr == ADDR_SUPPLY_FAIL_1))
    |=> st_r.sup1[SFS_MOV_BIT])
    else $error("regulator overvoltage flag dropped on its own");

  chk_warn_set: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && cmp_s.main_regulator_prewarning && !soft_reset_i) |=> st_r.sup1[SFS_WARN_BIT])
    else $error("prewarning not latched");

  chk_stop_uv_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && stop_mode_i && !peak_s && !st_r.sup1[SFS_WARN_BIT]) |=> !uv_monitor_on_o)
    else $error("undervoltage monitor on in quiet stop mode");

  chk_cp_ov_on: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && charge_pump_enable_i && main_regulator_output_i) |=> ov_monitor_on_o)
    else $error("overvoltage monitor off with charge pump on");

  chk_set_wins: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && !soft_reset_i && sup1_set[SFS_UV_BIT] && sup1_clr[SFS_UV_BIT]) |=> st_r.sup1[SFS_UV_BIT])
    else $error("undervoltage event lost to a clear");

  cov_read_frame: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    frame_ok && !st_r.rx[MODE_BIT_POS]);

  cov_clear_frame: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    clear_req && frame_addr == ADDR_SUPPLY_FAIL_1);

  cov_uv_event: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && sup1_set[SFS_UV_BIT] ##1 st_r.sup1[SFS_UV_BIT]);

endmodule

// ==== dv/ssrcb_host_model.sv ====
// spi master model of the host controller that reads and clears status bytes
`timescale 1ns/1ps
module ssrcb_host_model
(
  output logic spi_clk_o,        // spi clock, stands low between frames
  output logic spi_cs_n_o,       // chip select, active low
  output logic spi_mosi_o,       // data towards the bank
  input wire logic spi_miso_i,   // data from the bank
  output logic [7:0] rx_byte_o,  // data byte bits sampled in the last frame, full or short
  output logic rx_valid_o        // short strobe when a full 16-bit frame has made rx_byte_o new
);
  // ==========================================================================
  // idle levels
  initial
  begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
    rx_byte_o = 8'h00;
    rx_valid_o = 1'b0;
  end

  // ==========================================================================
  // one frame, lsb first; fewer than 16 bits makes a frame the bank must refuse
  task automatic frame(input logic [6:0] addr, input logic clr, input int nbits);
    logic [15:0] f;
    begin
      f = {8'h3C, clr, addr};
      spi_cs_n_o = 1'b0;
      // odd offset keeps the spi edges away from the bank clock edges
      #237;
      for (int i = 0; i < nbits; i++)
      begin
        spi_mosi_o = f[i];
        #200 spi_clk_o = 1'b1;
        #100;
        // miso changes after a falling edge, so it is taken midway through the high phase
        if (i >= 8)
          rx_byte_o[i-8] = spi_miso_i;
        #100 spi_clk_o = 1'b0;
      end
      #200 spi_mosi_o = ~spi_mosi_o; // released line shows no stale bit
      spi_cs_n_o = 1'b1;
      rx_valid_o = (nbits == 16);
      #200 rx_valid_o = 1'b0; // also the gap between frames
    end
  endtask
endmodule

// ==== dv/test_spi_status_read_clear_bank.sv ====
// self-checking bench for the spi status read/clear bank
`timescale 1ns/1ps
module test_spi_status_read_clear_bank;
  import ssrcb_pkg::*;
  localparam logic [7:0] FAM_ID = 8'h5C; // arbitrary identification value
  localparam int MAX_CYCLES = 30000;
  logic clk_i, arst_n_i, ce_i, soft_reset_i, restart_i;
  logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n, miso_line;
  ssrcb_cmp_type supply_cmp;
  logic load_peak, reg_on, stop_mode, charge_pump_enable, uv_mon, ov_mon, frame_done, rx_valid;
  logic [1:0] wd_cnt;
  logic [NUM_RC-1:0][7:0] status_event;
  logic [NUM_LEVEL-1:0][7:0] level_status;
  logic [7:0] rx_byte, v;
  logic [31:0] lfsr_r = 32'hEE4BE752;
  logic [7:0] exp_q[$];
  int failures, comparisons, cycles, done_seen, done_expected;

  // released miso line is pulled high
  assign miso_line = spi_miso_oe_n ? 1'b1 : spi_miso;

  ssrcb_bank #(.FAMILY_ID(FAM_ID)) ssrcb_bank_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .soft_reset_i(soft_reset_i), .restart_i(restart_i), .spi_clk_i(spi_clk), .spi_cs_n_i(spi_cs_n),
    .spi_mosi_i(spi_mosi), .spi_miso_o(spi_miso), .spi_miso_oe_n_o(spi_miso_oe_n), .supply_cmp_i(supply_cmp),
    .load_current_peak_i(load_peak), .main_regulator_output_i(reg_on), .stop_mode_i(stop_mode),
    .charge_pump_enable_i(charge_pump_enable), .watchdog_failure_counter_i(wd_cnt), .status_event_i(status_event),
    .level_status_i(level_status), .uv_monitor_on_o(uv_mon), .ov_monitor_on_o(ov_mon),
    .frame_done_o(frame_done));
  ssrcb_host_model ssrcb_host_model_inst (.spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n), .spi_mosi_o(spi_mosi),
    .spi_miso_i(miso_line), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid));

  // ==========================================================================
  // helpers
  function automatic logic [7:0] rnd8();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return lfsr_r[7:0];
  endfunction
  // device byte shows the live watchdog count in bits 3:2
  function automatic logic [7:0] exp_rc(input int i, input logic [7:0] b);
    if (i == RC_DEV_IDX)
      return (b & RC_LATCH_MASK[i]) | {4'h0, wd_cnt, 2'h0};
    return b;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask
  // the expected byte is noted before the frame starts
  task automatic access(input logic [6:0] addr, input logic clr, input logic [7:0] exp, input int nbits = 16);
    if (nbits == 16)
    begin
      exp_q.push_back(exp);
      done_expected++;
    end
    ssrcb_host_model_inst.frame(addr, clr, nbits);
    step(1);
  endtask
  task automatic pulse_cmp(input logic [3:0] c);
    supply_cmp = c;
    step(6);
    supply_cmp = '0;
    step(6);
  endtask
  task automatic mon(input logic uv, input logic ov);
    step(6);
    check({6'h00, uv_mon, ov_mon}, {6'h00, uv, ov});
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // clock, timeout and result watchers
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (frame_done === 1'b1)
      done_seen++;
    if (cycles == MAX_CYCLES)
    begin
      failures++;
      $display("ERROR %0t: timeout", $time);
      results();
    end
  end
  // oldest note is compared whenever the host finishes a full frame
  always @(posedge rx_valid)
  begin
    if (exp_q.size() == 0)
    begin
      failures++;
      $display("ERROR %0t: byte without expectation", $time);
    end
    else
      check(rx_byte, exp_q.pop_front());
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    {arst_n_i, soft_reset_i, restart_i, supply_cmp, load_peak, stop_mode, charge_pump_enable} = '0;
    {ce_i, reg_on} = 2'b11;
    status_event = '0;
    v = rnd8();
    wd_cnt = v[1:0];
    level_status = {rnd8(), rnd8(), rnd8()};
    step(2);
    arst_n_i = 1'b1;
    step(4);
    check({7'h00, spi_miso_oe_n}, 8'h01);
    access(ADDR_SUPPLY_FAIL_1, 1'b0, SFS_RESET);
    for (int i = 0; i < NUM_RC; i++)
      access(RC_ADDR[i], 1'b0, exp_rc(i, RC_RESET));
    access(ADDR_FAMILY_ID, 1'b1, FAM_ID);
    access(ADDR_WAKE_LEVEL, 1'b1, level_status[0]);
    access(ADDR_CDR_STATUS_1, 1'b0, level_status[1]);
    access(ADDR_CDR_STATUS_2, 1'b0, level_status[2]);
    access(ADDR_WAKE_LEVEL, 1'b0, level_status[0]);
    access(7'h45, 1'b0, 8'h00);
    access(7'h7F, 1'b0, 8'h00);
    access(7'h3F, 1'b1, 8'h00);
    $display("test reset_map done");
    // every generic byte: set, read, read with clear, read
    for (int i = 0; i < NUM_RC; i++)
    begin
      v = rnd8() | 8'h01;
      wd_cnt = v[5:4];
      status_event[i] = v;
      step(1);
      status_event[i] = 8'h00;
      access(RC_ADDR[i], 1'b0, exp_rc(i, v));
      access(RC_ADDR[i], 1'b1, exp_rc(i, v));
      access(RC_ADDR[i], 1'b0, exp_rc(i, 8'h00));
    end
    $display("test generic_bytes done");
    mon(1'b1, 1'b1);
    pulse_cmp(4'hF);
    access(ADDR_SUPPLY_FAIL_1, 1'b0, 8'h63);
    pulse(restart_i);
    access(ADDR_SUPPLY_FAIL_1, 1'b1, 8'h63);
    access(ADDR_SUPPLY_FAIL_1, 1'b0, 8'h00);
    reg_on = 1'b0;
    mon(1'b0, 1'b0);
    pulse_cmp(4'hF);
    access(ADDR_SUPPLY_FAIL_1, 1'b1, 8'h03);
    $display("test supply_flags done");
    {reg_on, stop_mode} = 2'b11;
    mon(1'b0, 1'b0);
    pulse_cmp(4'hC);
    charge_pump_enable = 1'b1;
    mon(1'b0, 1'b1);
    pulse_cmp(4'hC);
    access(ADDR_SUPPLY_FAIL_1, 1'b1, 8'h20);
    {charge_pump_enable, load_peak} = 2'b01;
    mon(1'b1, 1'b1);
    pulse_cmp(4'hC);
    access(ADDR_SUPPLY_FAIL_1, 1'b1, 8'h60);
    load_peak = 1'b0;
    pulse_cmp(4'h1);
    mon(1'b1, 1'b1);
    pulse_cmp(4'hC);
    access(ADDR_SUPPLY_FAIL_1, 1'b1, 8'h61);
    mon(1'b0, 1'b0);
    $display("test stop_mode done");
    // event held through the clear frame must survive it
    status_event[0] = 8'h81;
    access(RC_ADDR[0], 1'b1, 8'h81);
    status_event[0] = 8'h00;
    access(RC_ADDR[0], 1'b1, 8'h81, 15);
    access(RC_ADDR[0], 1'b0, 8'h81);
    ce_i = 1'b0;
    status_event[1] = 8'h3C;
    step(1);
    {ce_i, stop_mode} = 2'b10;
    status_event[1] = 8'h00;
    pulse_cmp(4'h3);
    pulse(restart_i);
    access(RC_ADDR[1], 1'b0, 8'h00);
    access(RC_ADDR[0], 1'b0, 8'h81);
    access(ADDR_SUPPLY_FAIL_1, 1'b0, 8'h03);
    // undervoltage held through a clear of its byte must survive it
    supply_cmp = 4'h8;
    step(6);
    access(ADDR_SUPPLY_FAIL_1, 1'b1, 8'h43);
    supply_cmp = '0;
    access(ADDR_SUPPLY_FAIL_1, 1'b0, 8'h40);
    pulse(soft_reset_i);
    access(RC_ADDR[0], 1'b0, 8'h00);
    access(ADDR_SUPPLY_FAIL_1, 1'b0, SFS_RESET);
    $display("test set_wins_resets done");
    step(5);
    check(done_seen[7:0], done_expected[7:0]);
    check(8'(exp_q.size()), 8'h00);
    results();
  end
endmodule
